// ==== msr_pkg.sv ====
// Package with constants and carrier types for the multiword shift register unit.
// Summary of operation
// - Decode three opcodes: unidirectional, reversible and word-position shift.
// - Unidirectional shift on rising shift input; data input enters bit 0.
// - Unidirectional shift drops the top bit; carry keeps its value, error flag is cleared.
// - Unidirectional reset input high clears every word of the span.
// - Reset input wins over shift and data inputs.
// - Unidirectional start above end: no error, only start word shifts.
// - Span is one register, start bit 0 lowest, end bit 15 highest.
// - Control word bits: 12 direction, 13 data, 14 shift, 15 reset.
// - Direction bit 1 shifts right, 0 shifts left.
// - Left shift: data into start bit 0, end bit 15 into carry.
// - Right shift: data into end bit 15, start bit 0 into carry.
// - Reversible reset bit holds span and carry at zero, ignoring shifts.
// - Carry takes the bit shifted out; reset clears it.
// - Reversible and word shifts set error when start exceeds end.
// - Word shift moves words toward end, source into start, end lost.
package msr_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 6;
    localparam int NWORDS = 64;
    localparam logic [7:0] OP_UNIDIR = 8'h10;
    localparam logic [7:0] OP_REVERS = 8'h84;
    localparam logic [7:0] OP_WORDSH = 8'h16;
    localparam int CTL_DIR = 12;
    localparam int CTL_DATA = 13;
    localparam int CTL_SHIFT = 14;
    localparam int CTL_RESET = 15;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam int STAT_DONE = 0;
    localparam int STAT_ERR = 1;
    localparam int STAT_CARRY = 2;
    localparam int STAT_W = 3;

    typedef struct packed {
        logic [7:0] opcode;
        logic [5:0] start_word;
        logic [5:0] end_word;
        logic [15:0] operand;
        logic data_in;
        logic shift_in;
        logic reset_in;
    } msr_cmd_s;

    typedef enum logic [1:0] {
        MSR_IDLE,
        MSR_RUN
    } msr_state_e;
endpackage

// ==== msr_props.sv ====
// Concurrent checks on the shift unit ports.
`timescale 1ns/10ps
module msr_props
    import msr_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_EXEC,
    input wire msr_cmd_s I_CMD,
    input wire logic O_BUSY,
    input wire logic O_ERROR,
    input wire logic O_CARRY
);
    logic tk;
    logic bad;
    logic rw;
    assign tk = I_EXEC && !O_BUSY;
    assign bad = I_CMD.start_word > I_CMD.end_word;
    assign rw = I_CMD.opcode == OP_REVERS || I_CMD.opcode == OP_WORDSH;
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_SRST);
    sequence walk_s;
        ##[2:70] $fell(O_BUSY);
    endsequence
    wsh_busy_a: assert property (tk && I_CMD.opcode == OP_WORDSH && !bad |=> O_BUSY)
        else $error("word shift did not start");
    one_word_a: assert property (tk && I_CMD.opcode == OP_WORDSH &&
        I_CMD.start_word == I_CMD.end_word |=> O_BUSY ##1 !O_BUSY)
        else $error("single word walk length wrong");
    err_set_a: assert property (tk && rw && bad |=> O_ERROR)
        else $error("error flag not raised");
    err_clr_a: assert property (tk && rw && !bad |=> !O_ERROR)
        else $error("error flag not cleared");
    uni_err_a: assert property (tk && I_CMD.opcode == OP_UNIDIR |=> !O_ERROR)
        else $error("error flag set by bit shift");
    uni_carry_a: assert property (tk && I_CMD.opcode == OP_UNIDIR |=> $stable(O_CARRY) [*3])
        else $error("carry moved by bit shift");
    err_keep_a: assert property (tk && rw && bad |=> $stable(O_CARRY) [*3])
        else $error("carry moved on error");
    rev_clear_a: assert property (tk && I_CMD.opcode == OP_REVERS && !bad &&
        I_CMD.operand[CTL_RESET] |-> walk_s ##1 !O_CARRY)
        else $error("carry not cleared by reset");
endmodule

// ==== msr_seq_model.sv ====
// Sequencer model that issues commands to the shift unit.
`timescale 1ns/10ps
module msr_seq_model
    import msr_pkg::*;
(
    input wire logic i_clk,
    output logic o_exec,
    output msr_cmd_s o_cmd
);
    initial begin
        o_exec = 1'b0;
        o_cmd = '0;
    end
    task automatic issue(input msr_cmd_s c, input int gap);
        repeat (gap) @(posedge i_clk);
        @(posedge i_clk);
        o_cmd <= c;
        o_exec <= 1'b1;
        @(posedge i_clk);
        o_exec <= 1'b0;
        o_cmd <= ~c;
    endtask
endmodule

// ==== msr_top.sv ====
// Multiword shift register unit: word memory, decoder and sequencing.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/10ps
module msr_top
    import msr_pkg::*;
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_SRST,
    // Instruction issue
    input wire logic I_EXEC,
    input wire msr_cmd_s I_CMD,
    // Register port
    input wire logic [ADDR_W-1:0] I_ADDR,
    input wire logic [WORD_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [WORD_W-1:0] O_RDATA,
    // Memory word access
    input wire logic [ADDR_W-1:0] I_MADDR,
    input wire logic [WORD_W-1:0] I_MWDATA,
    input wire logic I_MWR,
    output logic [WORD_W-1:0] O_MRDATA,
    // Status
    output logic O_BUSY,
    output logic O_ERROR,
    output logic O_CARRY,
    output logic O_IRQ
);
    localparam logic [ADDR_W-1:0] REG_STATUS = 6'h00;
    localparam logic [ADDR_W-1:0] REG_MASK = 6'h01;
    localparam logic [ADDR_W-1:0] REG_FLAGS = 6'h02;
    localparam logic [ADDR_W-1:0] REG_MAXLEN = 6'h03;

    logic [WORD_W-1:0] mem_q [NWORDS];
    msr_cmd_s cmd_q;
    msr_state_e state_q;
    logic [ADDR_W-1:0] ptr_q;
    logic [ADDR_W-1:0] last_q;
    logic right_q;
    logic clear_q;
    logic wmode_q;
    logic bit_q;
    logic [WORD_W-1:0] hold_q;
    logic shift_prev_q;
    logic err_q;
    logic carry_q;
    logic busy_q;
    logic [STAT_W-1:0] stat_q;
    logic [STAT_W-1:0] mask_q;
    logic [WORD_W-1:0] rdata_q;
    logic [WORD_W-1:0] mrdata_q;
    logic irq_q;
    logic [WORD_W-1:0] cur_word;
    logic [WORD_W-1:0] shifted;
    logic bit_out;
    logic done_ev;
    logic start_ok;
    logic is_uni;
    logic is_rev;
    logic is_wsh;
    logic do_op;
    logic rev_clear;
    logic rev_shift;
    logic do_idle;
    logic rev_right;
    logic uni_go;
    logic rw_go;
    logic launch;
    logic at_last;
    logic stat_rd;
    logic mask_wr;
    logic [STAT_W-1:0] stat_ev;
    logic [STAT_W-1:0] stat_d;
    logic [STAT_W-1:0] mask_d;

    // The walk wraps with the address width, so the memory must fill that space exactly.
    if (NWORDS != (1 << ADDR_W) || WORD_W != 16 || STAT_W > WORD_W) begin : g_size_check
        $error("word memory and field widths do not fit the shift datapath");
    end

    assign cur_word = mem_q[ptr_q];
    assign start_ok = I_CMD.start_word <= I_CMD.end_word;
    assign is_uni = I_CMD.opcode == OP_UNIDIR;
    assign is_rev = I_CMD.opcode == OP_REVERS;
    assign is_wsh = I_CMD.opcode == OP_WORDSH;
    assign rev_clear = I_CMD.operand[CTL_RESET];
    assign rev_shift = I_CMD.operand[CTL_SHIFT];
    assign do_op = I_EXEC && !busy_q;
    assign do_idle = do_op && state_q == MSR_IDLE;
    assign rev_right = is_rev && I_CMD.operand[CTL_DIR];
    assign uni_go = do_idle && is_uni
                    && (I_CMD.reset_in || (I_CMD.shift_in && !shift_prev_q));
    assign rw_go = do_idle && (is_rev || is_wsh) && start_ok
                   && (is_wsh || rev_clear || rev_shift);
    assign launch = uni_go || rw_go;
    assign at_last = state_q == MSR_RUN && ptr_q == last_q;

    msr_word_shift u_shift (
        .i_word(cur_word),
        .i_right(right_q),
        .i_bit(bit_q),
        .o_word(shifted),
        .o_bit(bit_out)
    );

    // Sequencer: one word per cycle from the first word toward the last.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            state_q <= MSR_IDLE;
            busy_q <= 1'b0;
        end else begin
            case (state_q)
                MSR_IDLE: begin
                    if (launch) begin
                        state_q <= MSR_RUN;
                        busy_q <= 1'b1;
                    end
                end
                MSR_RUN: begin
                    if (ptr_q == last_q) begin
                        state_q <= MSR_IDLE;
                        busy_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= MSR_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    // Completion pulse for every accepted command, walked or refused.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            done_ev <= 1'b0;
        end else begin
            done_ev <= (do_idle && !launch) || at_last;
        end
    end

    // Edge memory of the shift input, kept from one bit shift issue to the next.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            shift_prev_q <= 1'b0;
        end else if (do_idle && is_uni) begin
            shift_prev_q <= I_CMD.shift_in;
        end
    end

    // Command latch and the mode bits of the walk.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            cmd_q <= '0;
            right_q <= 1'b0;
            clear_q <= 1'b0;
            wmode_q <= 1'b0;
        end else if (launch) begin
            cmd_q <= I_CMD;
            right_q <= rev_right;
            clear_q <= (is_uni && I_CMD.reset_in) || (is_rev && rev_clear);
            wmode_q <= is_wsh;
        end
    end

    // Word pointer and the word at which the walk stops.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            ptr_q <= '0;
            last_q <= '0;
        end else if (launch) begin
            // right shift walks from the end word down
            ptr_q <= rev_right ? I_CMD.end_word : I_CMD.start_word;
            // start above end: start word only
            last_q <= (rev_right || !start_ok) ? I_CMD.start_word : I_CMD.end_word;
        end else if (state_q == MSR_RUN && ptr_q != last_q) begin
            ptr_q <= right_q ? ptr_q - 6'h01 : ptr_q + 6'h01;
        end
    end

    // Bit and word carried from one word of the walk to the next.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            bit_q <= 1'b0;
            hold_q <= WORD_RST;
        end else if (launch) begin
            // rising shift, data enters bit 0
            bit_q <= is_uni ? I_CMD.data_in : I_CMD.operand[CTL_DATA];
            hold_q <= I_CMD.operand;
        end else if (state_q == MSR_RUN) begin
            // bits chain from word to word as one register
            bit_q <= bit_out;
            // carry the old word into the next position
            hold_q <= cur_word;
        end
    end

    // Word memory: shift datapath writes, otherwise the access port.
    always_ff @(posedge I_CLK) begin
        if (state_q == MSR_RUN) begin
            if (clear_q) begin
                mem_q[ptr_q] <= WORD_RST;
            end else if (wmode_q) begin
                mem_q[ptr_q] <= hold_q;
            end else begin
                mem_q[ptr_q] <= shifted;
            end
        end else if (I_MWR) begin
            mem_q[I_MADDR] <= I_MWDATA;
        end
        mrdata_q <= mem_q[I_MADDR];
    end

    // Error flag, set or cleared by every accepted command of the three opcodes.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            err_q <= 1'b0;
        end else if (do_idle && is_uni) begin
            err_q <= 1'b0;
        end else if (do_idle && (is_rev || is_wsh)) begin
            // start above end flags an error
            err_q <= !start_ok;
        end
    end

    // Carry flag of the reversible register.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            carry_q <= 1'b0;
        end else if (rw_go && is_rev && rev_clear) begin
            carry_q <= 1'b0;
        end else if (at_last && !wmode_q && cmd_q.opcode == OP_REVERS && !clear_q) begin
            // left shift end bit 15 into carry
            carry_q <= bit_out;
        end
    end

    // Status events of the command that has just finished.
    always_comb begin
        stat_ev = '0;
        stat_ev[STAT_DONE] = done_ev;
        stat_ev[STAT_ERR] = done_ev && err_q;
        stat_ev[STAT_CARRY] = done_ev && carry_q;
    end

    assign stat_rd = I_RD && I_ADDR == REG_STATUS;
    assign mask_wr = I_WR && I_ADDR == REG_MASK;
    // A read clears the sticky bits, but an event in the same cycle wins.
    assign stat_d = stat_rd ? stat_ev : (stat_q | stat_ev);
    assign mask_d = mask_wr ? I_WDATA[STAT_W-1:0] : mask_q;

    // Sticky status, mask and level interrupt.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            stat_q <= '0;
            mask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q <= |(stat_d & mask_d);
        end
    end

    // Register reads, data valid only in the cycle after the strobe.
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            rdata_q <= '0;
        end else if (I_RD) begin
            case (I_ADDR)
                REG_STATUS: rdata_q <= {{(WORD_W-STAT_W){1'b0}}, stat_q};
                REG_MASK: rdata_q <= {{(WORD_W-STAT_W){1'b0}}, mask_q};
                REG_FLAGS: rdata_q <= {13'h0000, carry_q, err_q, busy_q};
                REG_MAXLEN: rdata_q <= 16'(NWORDS);
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign O_RDATA = rdata_q;
    assign O_MRDATA = mrdata_q;
    assign O_BUSY = busy_q;
    assign O_ERROR = err_q;
    assign O_CARRY = carry_q;
    assign O_IRQ = irq_q;
endmodule

// ==== msr_word_shift.sv ====
// One-word combinational shift step with bit input and outgoing bit.
`timescale 1ns/10ps
module msr_word_shift
    import msr_pkg::*;
(
    // Word and direction
    input wire logic [WORD_W-1:0] i_word,
    input wire logic i_right,
    input wire logic i_bit,
    // Result
    output logic [WORD_W-1:0] o_word,
    output logic o_bit
);
    always_comb begin
        if (i_right) begin
            o_word = {i_bit, i_word[WORD_W-1:1]};
            o_bit = i_word[0];
        end else begin
            o_word = {i_word[WORD_W-2:0], i_bit};
            o_bit = i_word[WORD_W-1];
        end
    end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the shift unit.
`timescale 1ns/10ps
module testbench;
    import msr_pkg::*;
    logic I_CLK, I_SRST, I_WR, I_RD, I_MWR, I_EXEC, O_BUSY, O_ERROR, O_CARRY, O_IRQ;
    logic [ADDR_W-1:0] I_ADDR, I_MADDR;
    logic [WORD_W-1:0] I_WDATA, I_MWDATA, O_RDATA, O_MRDATA, w;
    msr_cmd_s I_CMD, c;
    logic [WORD_W-1:0] m [NWORDS];
    logic [7:0] ops [3] = '{OP_UNIDIR, OP_REVERS, OP_WORDSH};
    logic cy, er, psh, mk;
    int seed = 41;
    int n_mismatch = 0;
    int tests_run = 0;
    int cyc = 0;
    int r;
    msr_top dut_u (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_EXEC(I_EXEC), .I_CMD(I_CMD),
        .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
        .I_MADDR(I_MADDR), .I_MWDATA(I_MWDATA), .I_MWR(I_MWR), .O_MRDATA(O_MRDATA),
        .O_BUSY(O_BUSY), .O_ERROR(O_ERROR), .O_CARRY(O_CARRY), .O_IRQ(O_IRQ));
    msr_seq_model seq_u (.i_clk(I_CLK), .o_exec(I_EXEC), .o_cmd(I_CMD));
    initial begin
        I_CLK = 1'b0;
        forever #12.5 I_CLK = ~I_CLK;
    end
    always @(posedge I_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge I_CLK);
        I_ADDR <= a;
        I_WDATA <= d;
        I_WR <= 1'b1;
        @(posedge I_CLK);
        I_WR <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a);
        @(posedge I_CLK);
        I_ADDR <= a;
        I_RD <= 1'b1;
        @(posedge I_CLK);
        I_RD <= 1'b0;
        #1;
    endtask
    function automatic void shl(int s, int e, logic d);
        for (int i = e; i >= s; i--) m[i] = {m[i][14:0], i == s ? d : m[i-1][15]};
    endfunction
    function automatic void model(msr_cmd_s c);
        int s, e;
        logic d;
        s = c.start_word;
        e = c.end_word;
        d = c.operand[CTL_DATA];
        if (c.opcode == OP_UNIDIR) begin
            er = 1'b0;
            if (e < s) e = s;
            if (c.reset_in) for (int i = s; i <= e; i++) m[i] = '0;
            else if (c.shift_in && !psh) shl(s, e, c.data_in);
            psh = c.shift_in;
        end else if (s > e) er = 1'b1;
        else begin
            er = 1'b0;
            if (c.opcode == OP_WORDSH) begin
                for (int i = e; i > s; i--) m[i] = m[i-1];
                m[s] = c.operand;
            end else if (c.operand[CTL_RESET]) begin
                for (int i = s; i <= e; i++) m[i] = '0;
                cy = 1'b0;
            end else if (c.operand[CTL_SHIFT] && c.operand[CTL_DIR]) begin
                cy = m[s][0];
                for (int i = s; i <= e; i++) m[i] = {i == e ? d : m[i+1][0], m[i][15:1]};
            end else if (c.operand[CTL_SHIFT]) begin
                cy = m[e][15];
                shl(s, e, d);
            end
        end
    endfunction
    task automatic run(msr_cmd_s c);
        seq_u.issue(c, r[14:13]);
        model(c);
        repeat (2) @(posedge I_CLK);
        #1;
        for (int n = 0; n < 80 && O_BUSY === 1'b1; n++) begin
            @(posedge I_CLK);
            #1;
        end
        repeat (2) @(posedge I_CLK);
        #1;
        check("error", O_ERROR, er);
        check("carry", O_CARRY, cy);
        check("irq", O_IRQ, mk);
        rd(6'h00);
        check("status", O_RDATA, {13'h0000, cy, er, 1'b1});
        @(posedge I_CLK);
        #1;
        check("irq clear", O_IRQ, 1'b0);
        rd(6'h02);
        check("flags", O_RDATA[2:0], {cy, er, 1'b0});
        for (int a = 0; a < NWORDS; a++) begin
            @(posedge I_CLK);
            I_MADDR <= a[5:0];
            @(posedge I_CLK);
            #1;
            check("word", O_MRDATA, m[a]);
        end
    endtask
    initial begin
        {I_SRST, I_WR, I_RD, I_MWR, I_ADDR, I_WDATA, I_MADDR, I_MWDATA} = '0;
        I_SRST = 1'b1;
        {cy, er, psh, mk, r} = '0;
        mk = 1'b1;
        repeat (4) @(posedge I_CLK);
        I_SRST <= 1'b0;
        for (int a = 0; a < NWORDS; a++) begin
            @(posedge I_CLK);
            w = 16'($random(seed));
            m[a] = w;
            I_MADDR <= a[5:0];
            I_MWDATA <= w;
            I_MWR <= 1'b1;
        end
        @(posedge I_CLK);
        I_MWR <= 1'b0;
        wr(6'h01, 16'h0001);
        rd(6'h01);
        check("mask", O_RDATA, 16'h0001);
        rd(6'h3F);
        check("unmapped", O_RDATA, 16'h0000);
        rd(6'h03);
        check("count", O_RDATA, 16'(NWORDS));
        c = '0;
        c.opcode = OP_UNIDIR;
        c.end_word = 6'h02;
        {c.shift_in, c.reset_in, c.data_in} = 3'h7;
        run(c);
        for (int i = 0; i < 30; i++) begin
            r = $random(seed);
            c.opcode = ops[i % 3];
            c.start_word = r[5:0];
            c.end_word = r[5:0] + r[8:6];
            if (i % 5 == 4) c.end_word = r[5:0] - 6'h01;
            if (i == 2) c.end_word = c.start_word;
            c.operand = 16'($random(seed));
            {c.data_in, c.shift_in} = r[10:9];
            c.reset_in = r[11] & r[12] & (c.start_word <= c.end_word);
            if (i == 24) begin
                wr(6'h01, 16'h0000);
                mk = 1'b0;
            end
            run(c);
        end
        // Reset between commands: flags, mask and edge memory restart, words stay.
        @(posedge I_CLK);
        I_SRST <= 1'b1;
        @(posedge I_CLK);
        I_SRST <= 1'b0;
        {cy, er, psh, mk} = '0;
        @(posedge I_CLK);
        #1;
        check("reset", {O_BUSY, O_ERROR, O_CARRY, O_IRQ}, 4'h0);
        c = '0;
        c.opcode = OP_UNIDIR;
        c.start_word = 6'h05;
        c.end_word = 6'h07;
        {c.shift_in, c.data_in} = 2'h3;
        run(c);
        wrap_up();
    end
endmodule
bind msr_top msr_props chk_u (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_EXEC(I_EXEC), .I_CMD(I_CMD),
    .O_BUSY(O_BUSY), .O_ERROR(O_ERROR), .O_CARRY(O_CARRY));
